//--- core/lfiv_pkg.sv
// Package for the legacy flags word block: field positions, masks, reset.
// Assumes a single core clock domain; used by lfiv_top, lfiv_checker and the testbench.
package lfiv_pkg;
	localparam int unsigned LFIV_WIDTH = 64;
	// Field positions inside the legacy status word
	localparam int unsigned LFIV_CARRY_POS = 0;
	localparam int unsigned LFIV_ONE_POS = 1;
	localparam int unsigned LFIV_PARITY_POS = 2;
	localparam int unsigned LFIV_ZERO3_POS = 3;
	localparam int unsigned LFIV_AUX_POS = 4;
	localparam int unsigned LFIV_ZERO5_POS = 5;
	localparam int unsigned LFIV_ZFLAG_POS = 6;
	localparam int unsigned LFIV_SIGN_POS = 7;
	localparam int unsigned LFIV_STEP_POS = 8;
	localparam int unsigned LFIV_IGATE_POS = 9;
	localparam int unsigned LFIV_DIR_POS = 10;
	localparam int unsigned LFIV_OVF_POS = 11;
	localparam int unsigned LFIV_IOPL_LO_POS = 12;
	localparam int unsigned LFIV_IOPL_HI_POS = 13;
	localparam int unsigned LFIV_NEST_POS = 14;
	localparam int unsigned LFIV_ZERO15_POS = 15;
	localparam int unsigned LFIV_RESUME_POS = 16;
	localparam int unsigned LFIV_V86_POS = 17;
	localparam int unsigned LFIV_ALIGN_POS = 18;
	localparam int unsigned LFIV_VIF_POS = 19;
	localparam int unsigned LFIV_VIP_POS = 20;
	localparam int unsigned LFIV_PROBE_POS = 21;
	// Bits that hold state (all defined flags except fixed ones)
	localparam logic [63:0] LFIV_STORE_MASK = 64'h0000_0000_003f_7fd5;
	// Bits that always read as one
	localparam logic [63:0] LFIV_ONE_MASK = 64'h0000_0000_0000_0002;
	// Bits that native writes must leave zero
	localparam logic [63:0] LFIV_RSVD_MASK = 64'hffff_ffff_ffc0_0000;
	// Value of the word after reset
	localparam logic [63:0] LFIV_RESET_VAL = 64'h0000_0000_0000_0002;
	// Source of a legacy write to the word
	typedef enum logic [1:0] {
		LFIV_SRC_NONE = 2'h0,
		LFIV_SRC_CLI = 2'h1,
		LFIV_SRC_STI = 2'h3,
		LFIV_SRC_POP = 2'h2
	} lfiv_src_t;
endpackage

//--- core/lfiv_top.sv
// Legacy status word with interrupt-enable gating and flag intercepts.
// Assumes the execution pipeline presents one write or retire per cycle.
//
// Operation
// RL1: No flag of the legacy status word affects native instruction execution; io privilege still gates native writes of the gate bit.
// RL2: Alignment, step, resume, virtual and privilege flags govern legacy only; io privilege also gates native writes of the gate bit.
// RL3: The nested task flag controls nothing; legacy writes to it trap.
// RL4: A native write with non-zero reserved bits raises a reserved fault.
// RL5: Legacy interrupts open when global enable and (no passthru or gate).
// RL6: Native interrupts open solely on the global enable.
// RL7: With the toggle trap on, a legacy gate change by cli/sti/pop traps.
// RL8: Bit 0 holds the carry flag for legacy arithmetic and branches.
// RL9: Bit 1 ignores writes and always reads one.
// RL10: Bits 3, 5 and 15 ignore writes and read zero.
// RL11: Interrupt gate virtualisation is independent of virtual-mode logic.
// RL12: Gate writes take effect only when privilege is at most io privilege.
// RL13: Single step raises a debug trap after each legacy instruction.
`timescale 1ns/1ps
module lfiv_top
	import lfiv_pkg::*;
(
	input wire logic SYS_CLK_IN, // Core clock, 40 MHz
	input wire logic RST_N_IN, // Asynchronous reset, active low
	input wire logic LEGACY_MODE_IN, // 1 while legacy code executes
	input wire logic NATIVE_WR_IN, // Native write of the flags register
	input wire logic [63:0] NATIVE_WDATA_IN, // Native write data
	input wire logic LEGACY_WR_IN, // Legacy instruction updates the word
	input wire lfiv_pkg::lfiv_src_t LEGACY_SRC_IN, // Which legacy writer
	input wire logic [63:0] LEGACY_WDATA_IN, // Legacy write data
	input wire logic LEGACY_RETIRE_IN, // Legacy instruction retired ok
	input wire logic GLOBAL_IRQ_EN_IN, // Global interrupt enable
	input wire logic [1:0] CUR_PRIV_IN, // Current privilege level
	input wire logic IRQ_PASSTHRU_IN, // Legacy irq mask passthru control
	input wire logic IRQ_TRAP_EN_IN, // Legacy irq toggle trap enable
	output logic [63:0] FLAGS_OUT, // Legacy status word read value
	output logic CARRY_OUT, // Carry flag for legacy ops
	output logic IRQ_ENABLE_OUT, // External interrupts enabled
	output logic RSVD_FAULT_OUT, // Reserved field fault pulse
	output logic FLAG_TRAP_OUT, // System flag intercept pulse
	output logic DEBUG_TRAP_OUT, // Single step debug trap pulse
	output logic LEGACY_CTRL_OUT // Legacy-only control flags active
);
	import lfiv_pkg::*;

	typedef struct packed {
		logic [63:0] word;
		logic carry;
		logic irq_en;
		logic rsvd_fault;
		logic flag_trap;
		logic dbg_trap;
		logic legacy_ctrl;
	} lfiv_state_t;

	lfiv_state_t s_q;
	lfiv_state_t s_d;

	// Sanitise a value into stored form: fixed bits forced
	function automatic logic [63:0] lfiv_clean(input logic [63:0] v);
		lfiv_clean = (v & LFIV_STORE_MASK) | LFIV_ONE_MASK;
	endfunction

	//////////////////////////////////////////////////////////////////////
	// Next state
	logic [63:0] wv;
	logic gate_ok;
	logic gate_change;
	logic [1:0] iopl;
	always_comb begin
		s_d = s_q;
		s_d.rsvd_fault = 1'b0;
		s_d.flag_trap = 1'b0;
		s_d.dbg_trap = 1'b0;
		iopl = s_q.word[LFIV_IOPL_HI_POS:LFIV_IOPL_LO_POS];
		gate_ok = (CUR_PRIV_IN <= iopl); // see RL12
		wv = s_q.word;
		gate_change = 1'b0;
		if (NATIVE_WR_IN && !LEGACY_MODE_IN) begin
			if ((NATIVE_WDATA_IN & LFIV_RSVD_MASK) != 64'h0) begin
				s_d.rsvd_fault = 1'b1; // see RL4
			end else begin
				wv = NATIVE_WDATA_IN;
				if (!gate_ok) begin
					wv[LFIV_IGATE_POS] = s_q.word[LFIV_IGATE_POS]; // see RL12
				end
				s_d.word = lfiv_clean(wv); // see RL9 see RL10
			end
		end else if (LEGACY_WR_IN && LEGACY_MODE_IN) begin
			wv = LEGACY_WDATA_IN;
			if (!gate_ok) begin
				wv[LFIV_IGATE_POS] = s_q.word[LFIV_IGATE_POS]; // see RL12
			end
			gate_change = wv[LFIV_IGATE_POS] != s_q.word[LFIV_IGATE_POS];
			// Gate toggle trap, independent of virtual-mode bits
			if (IRQ_TRAP_EN_IN && gate_change &&
					LEGACY_SRC_IN != LFIV_SRC_NONE) begin
				s_d.flag_trap = 1'b1; // see RL7 see RL11
			end
			// Nested task changes are always intercepted
			if (wv[LFIV_NEST_POS] != s_q.word[LFIV_NEST_POS]) begin
				s_d.flag_trap = 1'b1; // see RL3
			end
			// Step flag changed by pop is intercepted
			if (LEGACY_SRC_IN == LFIV_SRC_POP &&
					wv[LFIV_STEP_POS] != s_q.word[LFIV_STEP_POS]) begin
				s_d.flag_trap = 1'b1;
			end
			s_d.word = lfiv_clean(wv); // see RL9 see RL10
		end
		// Step trap only after legacy retire
		s_d.dbg_trap = LEGACY_MODE_IN && LEGACY_RETIRE_IN &&
			s_q.word[LFIV_STEP_POS]; // see RL13 see RL2
		s_d.carry = s_d.word[LFIV_CARRY_POS]; // see RL8
		// Interrupt enable per instruction set
		if (LEGACY_MODE_IN) begin
			s_d.irq_en = GLOBAL_IRQ_EN_IN && (!IRQ_PASSTHRU_IN ||
				s_d.word[LFIV_IGATE_POS]); // see RL5
		end else begin
			s_d.irq_en = GLOBAL_IRQ_EN_IN; // see RL6 see RL1
		end
		// Legacy controls only visible in legacy mode
		s_d.legacy_ctrl = LEGACY_MODE_IN && (s_d.word[LFIV_ALIGN_POS] ||
			s_d.word[LFIV_RESUME_POS] || s_d.word[LFIV_V86_POS] ||
			s_d.word[LFIV_VIF_POS] || s_d.word[LFIV_VIP_POS]); // see RL2
	end

	//////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			s_q <= '{word: LFIV_RESET_VAL, default: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Outputs straight from flops
	assign FLAGS_OUT = s_q.word;
	assign CARRY_OUT = s_q.carry;
	assign IRQ_ENABLE_OUT = s_q.irq_en;
	assign RSVD_FAULT_OUT = s_q.rsvd_fault;
	assign FLAG_TRAP_OUT = s_q.flag_trap;
	assign DEBUG_TRAP_OUT = s_q.dbg_trap;
	assign LEGACY_CTRL_OUT = s_q.legacy_ctrl;
endmodule

//--- sim/lfiv_checker.sv
// Checker for the legacy flags word block.
// Bound to lfiv_top; sees its ports only.
`timescale 1ns/1ps
module lfiv_checker
	import lfiv_pkg::*;
(
	input wire logic SYS_CLK_IN, // Clock
	input wire logic RST_N_IN, // Reset
	input wire logic LEGACY_MODE_IN, // Mode
	input wire logic NATIVE_WR_IN, // Write
	input wire logic [63:0] NATIVE_WDATA_IN, // Data
	input wire logic LEGACY_WR_IN, // Write
	input wire lfiv_pkg::lfiv_src_t LEGACY_SRC_IN, // Writer
	input wire logic [63:0] LEGACY_WDATA_IN, // Data
	input wire logic LEGACY_RETIRE_IN, // Retire
	input wire logic GLOBAL_IRQ_EN_IN, // Enable
	input wire logic [1:0] CUR_PRIV_IN, // Privilege
	input wire logic IRQ_PASSTHRU_IN, // Passthru
	input wire logic IRQ_TRAP_EN_IN, // Trap on
	input wire logic [63:0] FLAGS_OUT, // Word
	input wire logic CARRY_OUT, // Carry
	input wire logic IRQ_ENABLE_OUT, // Irq on
	input wire logic RSVD_FAULT_OUT, // Fault
	input wire logic FLAG_TRAP_OUT, // Trap
	input wire logic DEBUG_TRAP_OUT, // Step
	input wire logic LEGACY_CTRL_OUT // Ctrl
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	// Write that the block takes this edge
	wire logic wr = NATIVE_WR_IN && !LEGACY_MODE_IN || LEGACY_WR_IN && LEGACY_MODE_IN;
	////////////////////////////////////////////////////////////////////////
	// Fixed bits, carry, faults, gating, traps
	chk_fixed_bits: assert property (FLAGS_OUT[1] && !FLAGS_OUT[3]
		&& !FLAGS_OUT[5] && !FLAGS_OUT[15]) else $error("fixed bit wrong");
	chk_carry_bit: assert property (CARRY_OUT == FLAGS_OUT[0])
		else $error("carry differs from bit 0");
	chk_rsvd_fault: assert property (NATIVE_WR_IN && !LEGACY_MODE_IN
		&& |NATIVE_WDATA_IN[63:22] |=> RSVD_FAULT_OUT && $stable(FLAGS_OUT))
		else $error("reserved write not refused");
	chk_irq_native: assert property (!LEGACY_MODE_IN |=>
		IRQ_ENABLE_OUT == $past(GLOBAL_IRQ_EN_IN)) else $error("native irq");
	chk_irq_legacy: assert property (LEGACY_MODE_IN |=> IRQ_ENABLE_OUT ==
		($past(GLOBAL_IRQ_EN_IN) && (!$past(IRQ_PASSTHRU_IN) || FLAGS_OUT[9])))
		else $error("legacy irq");
	chk_gate_trap: assert property (LEGACY_WR_IN && LEGACY_MODE_IN
		&& IRQ_TRAP_EN_IN && LEGACY_SRC_IN != LFIV_SRC_NONE ##1
		$changed(FLAGS_OUT[9]) |-> FLAG_TRAP_OUT) else $error("no gate trap");
	chk_gate_priv: assert property (wr && CUR_PRIV_IN > FLAGS_OUT[13:12]
		|=> $stable(FLAGS_OUT[9])) else $error("gate changed by low privilege");
	chk_step_legacy: assert property (DEBUG_TRAP_OUT |->
		$past(LEGACY_MODE_IN && LEGACY_RETIRE_IN)) else $error("stray step trap");
	chk_step_fires: assert property (LEGACY_MODE_IN && LEGACY_RETIRE_IN
		&& FLAGS_OUT[8] |=> DEBUG_TRAP_OUT) else $error("missing step trap");
	chk_ctrl_native: assert property (!LEGACY_MODE_IN |=>
		!LEGACY_CTRL_OUT) else $error("legacy control seen in native mode");
	// Main scenarios reached
	cover property (FLAG_TRAP_OUT);
	cover property (RSVD_FAULT_OUT);
	cover property (LEGACY_MODE_IN && IRQ_ENABLE_OUT);
endmodule
bind lfiv_top lfiv_checker u_chk (.*);

//--- sim/lfiv_pipe.sv
// Pipeline side model: the interrupt and privilege levels it presents.
// Assumes the bench changes ctl_in just after a clock edge.
`timescale 1ns/1ps
module lfiv_pipe (
	input wire logic [4:0] ctl_in, // Chosen levels
	output logic glob_out, // Global enable
	output logic pass_out, // Mask passthru
	output logic trap_en_out, // Toggle trap on
	output logic [1:0] priv_out // Privilege
);
	// Levels held steady across the whole write cycle
	assign {glob_out, pass_out, trap_en_out, priv_out} = ctl_in;
endmodule

//--- sim/lfiv_tb.sv
// Self-checking bench for lfiv_top against an integer flags model.
// Assumes one write per cycle, answered one cycle later.
`timescale 1ns/1ps
module testbench;
	import lfiv_pkg::*;
	logic SYS_CLK_IN = 0, RST_N_IN = 0, LEGACY_MODE_IN = 0, NATIVE_WR_IN = 0;
	logic LEGACY_WR_IN = 0, LEGACY_RETIRE_IN = 0, GLOBAL_IRQ_EN_IN;
	logic IRQ_PASSTHRU_IN, IRQ_TRAP_EN_IN, CARRY_OUT, IRQ_ENABLE_OUT;
	logic RSVD_FAULT_OUT, FLAG_TRAP_OUT, DEBUG_TRAP_OUT, LEGACY_CTRL_OUT;
	logic [63:0] NATIVE_WDATA_IN = 0, LEGACY_WDATA_IN = 0, FLAGS_OUT;
	logic [63:0] w = LFIV_RESET_VAL;
	logic [1:0] CUR_PRIV_IN;
	lfiv_src_t LEGACY_SRC_IN = LFIV_SRC_NONE;
	logic [15:0] r = 16'hb801;
	logic [4:0] ctl = 5'h00;
	int fails = 0, num_checks = 0;
	lfiv_top DUT (.*);
	lfiv_pipe u_pipe (.ctl_in(ctl), .glob_out(GLOBAL_IRQ_EN_IN),
		.pass_out(IRQ_PASSTHRU_IN), .trap_en_out(IRQ_TRAP_EN_IN),
		.priv_out(CUR_PRIV_IN));
	always #12.5 SYS_CLK_IN = ~SYS_CLK_IN;
	////////////////////////////////////////////////////////////////////////
	// Random source, comparison and verdict
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task chk(input logic [69:0] s, input logic [69:0] e);
		num_checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED %0t saw %h want %h", $time, s, e);
		end
	endtask
	task end_of_test();
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// One write through the model and the design, compared next cycle
	task op(input logic nat, input lfiv_src_t s, input logic [63:0] d);
		logic [63:0] n;
		logic f;
		logic t;
		r = lfsr(r);
		ctl = r[4:0];
		f = nat && |(d & LFIV_RSVD_MASK);
		n = f ? w : (d & LFIV_STORE_MASK) | LFIV_ONE_MASK;
		if (ctl[1:0] > w[13:12])
			n[9] = w[9];
		t = !nat && (ctl[2] && s != LFIV_SRC_NONE && n[9] != w[9]
			|| n[14] != w[14] || s == LFIV_SRC_POP && n[8] != w[8]);
		LEGACY_MODE_IN = !nat;
		NATIVE_WR_IN = nat;
		LEGACY_WR_IN = !nat;
		LEGACY_SRC_IN = s;
		NATIVE_WDATA_IN = d;
		LEGACY_WDATA_IN = d;
		LEGACY_RETIRE_IN = 1'b1;
		@(posedge SYS_CLK_IN);
		#1;
		chk({FLAGS_OUT, CARRY_OUT, IRQ_ENABLE_OUT, RSVD_FAULT_OUT,
			FLAG_TRAP_OUT, DEBUG_TRAP_OUT, LEGACY_CTRL_OUT},
			{n, n[0], ctl[4] && (nat || !ctl[3] || n[9]), f, t,
			!nat && w[8], !nat && |n[20:16]});
		w = n;
	endtask
	// Reset, boundary writes, then random native and legacy traffic
	initial begin
		repeat (3) @(posedge SYS_CLK_IN);
		#1 RST_N_IN = 1'b1;
		chk({FLAGS_OUT, CARRY_OUT, IRQ_ENABLE_OUT, RSVD_FAULT_OUT,
			FLAG_TRAP_OUT, DEBUG_TRAP_OUT, LEGACY_CTRL_OUT},
			{LFIV_RESET_VAL, 6'h00});
		op(1'b1, LFIV_SRC_NONE, 64'hffff_ffff_ffff_ffff);
		op(1'b1, LFIV_SRC_NONE, 64'h0000_0000_003f_ffff);
		op(1'b1, LFIV_SRC_NONE, 64'h0000_0000_0040_0000);
		for (int i = 0; i < 200; i++)
			op(r[5], lfiv_src_t'(r[7:6]), r[8] ? {4{r}} : {42'h0, r[5:0], r});
		end_of_test();
	end
endmodule
